// ---- rtl/bxs_pkg.sv ----
package bxs_pkg;

   // ---------------------------------------------------------------
   // Register map, byte addresses
   // ---------------------------------------------------------------
   localparam int unsigned BXS_ADDR_W = 8;
   localparam logic [7:0] BXS_OFS_MEM0_BASE = 8'h98;
   localparam logic [7:0] BXS_OFS_MEM0_SETUP = 8'h9C;
   localparam logic [7:0] BXS_OFS_SLOT_ID = 8'hA0;
   localparam logic [7:0] BXS_OFS_CLK_CTRL = 8'hA4;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned BXS_BASE_LSB = 12;
   localparam int unsigned BXS_BASE_W = 20;
   localparam int unsigned BXS_SIZE_W = 19;
   localparam int unsigned BXS_SETUP_TYPE_BIT = 0;
   localparam int unsigned BXS_SETUP_ATYPE_LSB = 1;
   localparam int unsigned BXS_SETUP_PREF_BIT = 3;
   localparam int unsigned BXS_SETUP_EN_BIT = 31;
   localparam int unsigned BXS_CAP_ID_LSB = 0;
   localparam int unsigned BXS_NEXT_PTR_LSB = 8;
   localparam int unsigned BXS_SLOT_NUM_LSB = 16;
   localparam int unsigned BXS_FIRST_BIT = 21;
   localparam int unsigned BXS_CHASSIS_LSB = 24;
   localparam int unsigned BXS_CLK0_LSB = 0;
   localparam int unsigned BXS_CLK1_LSB = 2;

   // ---------------------------------------------------------------
   // Reset and fixed values
   // ---------------------------------------------------------------
   localparam logic [19:0] BXS_BASE_RESET = 20'h00000;
   localparam logic [18:0] BXS_SIZE_RESET = 19'h7FFFF;
   localparam logic [1:0] BXS_ATYPE_RESET = 2'h0;
   localparam logic [1:0] BXS_ATYPE_32 = 2'h0;
   localparam logic [1:0] BXS_ATYPE_64 = 2'h1;
   localparam logic BXS_TYPE_MEMORY = 1'b0;
   localparam logic [19:0] BXS_PROBE_READ = 20'hFFFFF;
   localparam logic [7:0] BXS_CAP_ID = 8'h04;
   localparam logic [7:0] BXS_NEXT_PTR = 8'hB0;
   localparam logic [4:0] BXS_SLOT_RESET = 5'h00;
   localparam logic [7:0] BXS_CHASSIS_RESET = 8'h00;
   localparam logic [1:0] BXS_CLK_EN_RESET = 2'h0;
   localparam logic [1:0] BXS_CLK_OFF = 2'h3;

   typedef enum logic [1:0]
   {
      BXS_BUS_IDLE = 2'b01,
      BXS_BUS_ACK = 2'b10
   } bxs_bus_state_t;

endpackage

// ---- rtl/bxs_addr_xlate.sv ----
module bxs_addr_xlate
   import bxs_pkg::*;
#(
   parameter int unsigned ADDR_W = 32
)
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic hit_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [ADDR_W-1:0] base_i,
   input wire logic [ADDR_W-1:0] mask_i,
   output logic [ADDR_W-1:0] addr_o,
   output logic valid_o
);

   logic [ADDR_W-1:0] addr_reg;
   logic valid_reg;

   // ---------------------------------------------------------------
   // Translation: base bits where the mask is set, input bits elsewhere
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         addr_reg <= '0;
         valid_reg <= 1'b0;
      end
      else
      begin
         valid_reg <= hit_i;
         if (hit_i)
         begin
            addr_reg <= (addr_i & ~mask_i) | (base_i & mask_i);
         end
      end
   end

   assign addr_o = addr_reg;
   assign valid_o = valid_reg;

   xlate_merge_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      hit_i |=> valid_o && (addr_o == (($past(addr_i) & ~$past(mask_i))
                                      | ($past(base_i) & $past(mask_i)))))
      else $error("translated address does not merge base and offset");

endmodule

// ---- rtl/bxs_cfg_regs.sv ----
// Summary of operation
// - Translated base bits 31:12 are read/write, reset zero, replace window addresses.
// - Which translated base bits are used comes from the setup size mask.
// - Setup bit 0 always reads 0, meaning memory space.
// - Address type bits 2:1 load only at setup time; reset 00.
// - Size mask bits 30:12 load at setup time, reset 7FFFFh, set base writability.
// - Enable bit 31 stays 1; after a zero write base reads FFFFFh.
// - Capability identifier bits 7:0 always read 04h.
// - Next capability pointer bits 15:8 always read B0h.
// - Slot 0 clock field bits 1:0 reset 00; value 11 stops clock low.
// - Slot 1 clock field bits 3:2 reset 00; value 11 stops clock low.
//
// Decided for this implementation: register access over Avalon-MM.
module bxs_cfg_regs
   import bxs_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [BXS_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic setup_load_en_i,
   input wire logic mem0_hit_i,
   input wire logic [31:0] mem0_addr_i,
   output logic [31:0] mem0_xlate_addr_o,
   output logic mem0_xlate_valid_o,
   output logic [1:0] mem0_addr_type_o,
   output logic mem0_prefetch_o,
   output logic slot0_secondary_clock_out_o,
   output logic slot1_secondary_clock_out_o
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   bxs_bus_state_t bus_state_reg;
   bxs_bus_state_t bus_state_next;
   logic [31:0] rd_data_reg;
   logic [31:0] rd_data_next;
   logic [BXS_BASE_W-1:0] base_reg;
   logic [BXS_SIZE_W-1:0] size_mask_reg;
   logic [1:0] addr_type_reg;
   logic prefetch_reg;
   logic probe_reg;
   logic [4:0] slot_num_reg;
   logic first_in_chassis_reg;
   logic [7:0] chassis_reg;
   logic [1:0] clk0_en_reg;
   logic [1:0] clk1_en_reg;
   logic clk0_out_reg;
   logic clk1_out_reg;
   logic setup_meta_reg;
   logic setup_sync_reg;
   logic bus_req;
   logic wr_commit;
   logic [31:0] be_mask;
   logic [BXS_BASE_W-1:0] base_wr_mask;
   logic [31:0] xlate_mask;
   logic [31:0] setup_word;
   logic [31:0] slot_word;
   logic [31:0] clk_word;
   logic [31:0] base_word;
   logic sel_base;
   logic sel_setup;
   logic sel_slot;
   logic sel_clk;

   // ---------------------------------------------------------------
   // Bus handshake
   // ---------------------------------------------------------------
   // One wait state per access: data is captured on the first edge and
   // presented with waitrequest low in the following cycle.
   assign bus_req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = bus_req & (bus_state_reg != BXS_BUS_ACK);
   assign wr_commit = avs_write_i & (bus_state_reg == BXS_BUS_ACK);

   always_comb
   begin
      bus_state_next = bus_state_reg;
      case (bus_state_reg)
         BXS_BUS_IDLE:
         begin
            if (bus_req)
            begin
               bus_state_next = BXS_BUS_ACK;
            end
         end
         BXS_BUS_ACK:
         begin
            bus_state_next = BXS_BUS_IDLE;
         end
         default:
         begin
            bus_state_next = BXS_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         bus_state_reg <= BXS_BUS_IDLE;
      end
      else
      begin
         bus_state_reg <= bus_state_next;
      end
   end

   // ---------------------------------------------------------------
   // Address decode and byte lanes
   // ---------------------------------------------------------------
   assign sel_base = (avs_address_i == BXS_OFS_MEM0_BASE);
   assign sel_setup = (avs_address_i == BXS_OFS_MEM0_SETUP);
   assign sel_slot = (avs_address_i == BXS_OFS_SLOT_ID);
   assign sel_clk = (avs_address_i == BXS_OFS_CLK_CTRL);

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_lane
         assign be_mask[gi*8 +: 8] = {8{avs_byteenable_i[gi]}};
      end
   endgenerate

   // ---------------------------------------------------------------
   // Setup-time load strap
   // ---------------------------------------------------------------
   // Pin input, so two flops before anything looks at it.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         setup_meta_reg <= 1'b0;
         setup_sync_reg <= 1'b0;
      end
      else
      begin
         setup_meta_reg <= setup_load_en_i;
         setup_sync_reg <= setup_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // Memory-0 translated base
   // ---------------------------------------------------------------
   // Bit 31 is covered by the always-set enable, so it is always writable.
   assign base_wr_mask = {1'b1, size_mask_reg} & be_mask[31:BXS_BASE_LSB];

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         base_reg <= BXS_BASE_RESET;
      end
      else if (wr_commit && sel_base)
      begin
         base_reg <= (base_reg & ~base_wr_mask)
                   | (avs_writedata_i[31:BXS_BASE_LSB] & base_wr_mask);
      end
   end

   // ---------------------------------------------------------------
   // Memory-0 setup
   // ---------------------------------------------------------------
   // Fields are frozen once the setup strap is low, so runtime software
   // cannot resize a window behind the host's back.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         addr_type_reg <= BXS_ATYPE_RESET;
         prefetch_reg <= 1'b0;
         size_mask_reg <= BXS_SIZE_RESET;
      end
      else if (wr_commit && sel_setup && setup_sync_reg)
      begin
         if (avs_byteenable_i[0])
         begin
            addr_type_reg <= avs_writedata_i[BXS_SETUP_ATYPE_LSB +: 2];
            prefetch_reg <= avs_writedata_i[BXS_SETUP_PREF_BIT];
         end
         size_mask_reg <= (size_mask_reg & ~be_mask[30:BXS_BASE_LSB])
                        | (avs_writedata_i[30:BXS_BASE_LSB] & be_mask[30:BXS_BASE_LSB]);
      end
   end

   // Zero written to the enable bit: base reads all ones until rewritten.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         probe_reg <= 1'b0;
      end
      else if (wr_commit && sel_setup && avs_byteenable_i[3])
      begin
         probe_reg <= ~avs_writedata_i[BXS_SETUP_EN_BIT];
      end
      else if (wr_commit && sel_base)
      begin
         probe_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Slot identification
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         slot_num_reg <= BXS_SLOT_RESET;
         first_in_chassis_reg <= 1'b0;
         chassis_reg <= BXS_CHASSIS_RESET;
      end
      else if (wr_commit && sel_slot)
      begin
         if (avs_byteenable_i[2])
         begin
            slot_num_reg <= avs_writedata_i[BXS_SLOT_NUM_LSB +: 5];
            first_in_chassis_reg <= avs_writedata_i[BXS_FIRST_BIT];
         end
         if (avs_byteenable_i[3])
         begin
            chassis_reg <= avs_writedata_i[BXS_CHASSIS_LSB +: 8];
         end
      end
   end

   // ---------------------------------------------------------------
   // Secondary clock outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         clk0_en_reg <= BXS_CLK_EN_RESET;
         clk1_en_reg <= BXS_CLK_EN_RESET;
      end
      else if (wr_commit && sel_clk && avs_byteenable_i[0])
      begin
         clk0_en_reg <= avs_writedata_i[BXS_CLK0_LSB +: 2];
         clk1_en_reg <= avs_writedata_i[BXS_CLK1_LSB +: 2];
      end
   end

   // Divide by two; a stopped output parks low so restart is glitch free.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         clk0_out_reg <= 1'b0;
         clk1_out_reg <= 1'b0;
      end
      else
      begin
         clk0_out_reg <= (clk0_en_reg == BXS_CLK_OFF) ? 1'b0 : ~clk0_out_reg;
         clk1_out_reg <= (clk1_en_reg == BXS_CLK_OFF) ? 1'b0 : ~clk1_out_reg;
      end
   end

   assign slot0_secondary_clock_out_o = clk0_out_reg;
   assign slot1_secondary_clock_out_o = clk1_out_reg;

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   always_comb
   begin
      base_word = probe_reg ? {BXS_PROBE_READ, 12'h000}
                            : {base_reg, 12'h000};
      setup_word = '0;
      setup_word[BXS_SETUP_EN_BIT] = 1'b1;
      setup_word[30:BXS_BASE_LSB] = size_mask_reg;
      setup_word[BXS_SETUP_PREF_BIT] = prefetch_reg;
      setup_word[BXS_SETUP_ATYPE_LSB +: 2] = addr_type_reg;
      setup_word[BXS_SETUP_TYPE_BIT] = BXS_TYPE_MEMORY;
      slot_word = '0;
      slot_word[BXS_CAP_ID_LSB +: 8] = BXS_CAP_ID;
      slot_word[BXS_NEXT_PTR_LSB +: 8] = BXS_NEXT_PTR;
      slot_word[BXS_SLOT_NUM_LSB +: 5] = slot_num_reg;
      slot_word[BXS_FIRST_BIT] = first_in_chassis_reg;
      slot_word[BXS_CHASSIS_LSB +: 8] = chassis_reg;
      clk_word = '0;
      clk_word[BXS_CLK0_LSB +: 2] = clk0_en_reg;
      clk_word[BXS_CLK1_LSB +: 2] = clk1_en_reg;
      if (sel_base)
      begin
         rd_data_next = base_word;
      end
      else if (sel_setup)
      begin
         rd_data_next = setup_word;
      end
      else if (sel_slot)
      begin
         rd_data_next = slot_word;
      end
      else if (sel_clk)
      begin
         rd_data_next = clk_word;
      end
      else
      begin
         rd_data_next = '0;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         rd_data_reg <= '0;
      end
      else if (avs_read_i && bus_state_reg == BXS_BUS_IDLE)
      begin
         rd_data_reg <= rd_data_next;
      end
   end

   assign avs_readdata_o = rd_data_reg;

   // ---------------------------------------------------------------
   // Window translation
   // ---------------------------------------------------------------
   assign xlate_mask = {1'b1, size_mask_reg, 12'h000};
   assign mem0_addr_type_o = addr_type_reg;
   assign mem0_prefetch_o = prefetch_reg;

   bxs_addr_xlate #(
      .ADDR_W(32)
   ) u_xlate (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .hit_i(mem0_hit_i),
      .addr_i(mem0_addr_i),
      .base_i({base_reg, 12'h000}),
      .mask_i(xlate_mask),
      .addr_o(mem0_xlate_addr_o),
      .valid_o(mem0_xlate_valid_o)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   bus_answer_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (bus_req && bus_state_reg == BXS_BUS_IDLE) |-> avs_waitrequest_o
         ##1 (!bus_req || !avs_waitrequest_o))
      else $error("bus access not answered after one wait state");

   base_reset_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> (base_reg == BXS_BASE_RESET) && !probe_reg)
      else $error("translated base not cleared by reset");

   base_ro_bits_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr_commit && sel_base) |=>
         ((base_reg[18:0] & ~size_mask_reg) == ($past(base_reg[18:0]) & ~size_mask_reg)))
      else $error("read-only base bit changed on write");

   base_rw_bits_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr_commit && sel_base && avs_byteenable_i == 4'hF) |=>
         ((base_reg & {1'b1, size_mask_reg})
            == ($past(avs_writedata_i[31:12]) & {1'b1, size_mask_reg})))
      else $error("writable base bit not stored");

   type_mem_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (avs_read_i && sel_setup && !avs_waitrequest_o)
         |-> !avs_readdata_o[BXS_SETUP_TYPE_BIT] && avs_readdata_o[BXS_SETUP_EN_BIT])
      else $error("setup type or enable bit read wrong");

   setup_locked_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr_commit && sel_setup && !setup_sync_reg) |=>
         $stable(size_mask_reg) && $stable(addr_type_reg) && $stable(prefetch_reg))
      else $error("setup field changed outside setup time");

   probe_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr_commit && sel_setup && avs_byteenable_i[3] && !avs_writedata_i[31])
         ##1 (avs_read_i && sel_base && bus_state_reg == BXS_BUS_IDLE)
         |=> avs_readdata_o[31:12] == 20'hFFFFF)
      else $error("base did not read all ones after enable write");

   cap_header_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (avs_read_i && sel_slot && !avs_waitrequest_o)
         |-> avs_readdata_o[15:0] == 16'hB004 && avs_readdata_o[23:22] == 2'h0)
      else $error("capability header or reserved bits read wrong");

   slot_store_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr_commit && sel_slot && avs_byteenable_i[3]) |=>
         chassis_reg == $past(avs_writedata_i[31:24]))
      else $error("chassis number not stored");

   clk0_stop_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (clk0_en_reg == 2'h3) [*2] |-> !slot0_secondary_clock_out_o)
      else $error("slot 0 clock not held low when stopped");

   clk0_run_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (clk0_en_reg != 2'h3) [*2] |-> slot0_secondary_clock_out_o
         != $past(slot0_secondary_clock_out_o))
      else $error("slot 0 clock not toggling when enabled");

   clk1_stop_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (clk1_en_reg == 2'h3) [*2] |-> !slot1_secondary_clock_out_o)
      else $error("slot 1 clock not held low when stopped");

   clk1_run_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (clk1_en_reg != 2'h3) [*2] |-> slot1_secondary_clock_out_o
         != $past(slot1_secondary_clock_out_o))
      else $error("slot 1 clock not toggling when enabled");

endmodule

// ---- verif/tb_top.sv ----
module tb_top;
   import bxs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {logic [7:0] a; logic wr; logic [31:0] d; logic [3:0] be; logic [31:0] e;} bxs_tb_row_t;

   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic setup_load_en_i = 1'b0;
   logic mem0_hit_i = 1'b0;
   logic [31:0] mem0_addr_i = 32'h0;
   logic [31:0] mem0_xlate_addr_o;
   logic mem0_xlate_valid_o;
   logic [1:0] mem0_addr_type_o;
   logic mem0_prefetch_o;
   logic slot0_secondary_clock_out_o;
   logic slot1_secondary_clock_out_o;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] rd;

   // ---------------------------------------------------------------
   // Ordinary cases: reset values, then write and read back
   // ---------------------------------------------------------------
   bxs_tb_row_t rows [0:10] = '{
      '{8'h98, 1'b0, 32'h0, 4'h0, 32'h0000_0000},
      '{8'h9C, 1'b0, 32'h0, 4'h0, 32'hFFFF_F000},
      '{8'hA0, 1'b0, 32'h0, 4'h0, 32'h0000_B004},
      '{8'hA4, 1'b0, 32'h0, 4'h0, 32'h0000_0000},
      '{8'h98, 1'b1, 32'hFFFF_FFFF, 4'hF, 32'hFFFF_F000},
      '{8'h9C, 1'b1, 32'h8000_000F, 4'hF, 32'hFFFF_F000},
      '{8'hA0, 1'b1, 32'hFFFF_FFFF, 4'hF, 32'hFF3F_B004},
      '{8'hA0, 1'b1, 32'h1234_5678, 4'h8, 32'h123F_B004},
      '{8'hA4, 1'b1, 32'hFFFF_FFFF, 4'hF, 32'h0000_000F},
      '{8'h90, 1'b1, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000},
      '{8'hA4, 1'b1, 32'h0000_0000, 4'hF, 32'h0000_0000}};

   bxs_cfg_regs bxs_cfg_regs_i (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .setup_load_en_i(setup_load_en_i),
      .mem0_hit_i(mem0_hit_i),
      .mem0_addr_i(mem0_addr_i),
      .mem0_xlate_addr_o(mem0_xlate_addr_o),
      .mem0_xlate_valid_o(mem0_xlate_valid_o),
      .mem0_addr_type_o(mem0_addr_type_o),
      .mem0_prefetch_o(mem0_prefetch_o),
      .slot0_secondary_clock_out_o(slot0_secondary_clock_out_o),
      .slot1_secondary_clock_out_o(slot1_secondary_clock_out_o)
   );

   initial
   begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   task automatic finish_test();
      $display("checks_done=%0d errors=%0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Runs take well under 2000 cycles; the ceiling leaves ample margin
   always @(posedge clk_sys_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors = errors + 1;
         finish_test();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done = checks_done + 1;
      if (g !== e)
      begin
         errors = errors + 1;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   // ---------------------------------------------------------------
   // Avalon master: hold the request until waitrequest is seen low
   // ---------------------------------------------------------------
   task automatic bus_op(input logic wr, input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] be, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      do
      begin
         @(posedge clk_sys_i);
         n = n + 1;
      end
      while (avs_waitrequest_o !== 1'b0 && n < 50);
      q = avs_readdata_o;
      if (n >= 50)
         chk("waitrequest", 32'h0, 32'h1);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask

   task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus_op(1'b0, a, 32'h0, 4'hF, q);
      chk(n, e, q);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus_op(1'b1, a, d, 4'hF, q);
   endtask

   // A running output flips every cycle; a stopped one stays low
   task automatic clk_chk(input logic run0, input logic run1);
      logic p0;
      logic p1;
      @(posedge clk_sys_i);
      p0 = slot0_secondary_clock_out_o;
      p1 = slot1_secondary_clock_out_o;
      repeat (4)
      begin
         @(posedge clk_sys_i);
         chk("slot0_secondary_clock_out", run0 ? {31'h0, ~p0} : 32'h0, {31'h0, slot0_secondary_clock_out_o});
         chk("slot1_secondary_clock_out", run1 ? {31'h0, ~p1} : 32'h0, {31'h0, slot1_secondary_clock_out_o});
         p0 = slot0_secondary_clock_out_o;
         p1 = slot1_secondary_clock_out_o;
      end
   endtask

   initial
   begin
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].wr)
            bus_op(1'b1, rows[i].a, rows[i].d, rows[i].be, rd);
         rd_chk("table row", rows[i].a, rows[i].e);
      end
      // Every code of both clock enable fields
      for (int c = 0; c < 16; c++)
      begin
         wr(8'hA4, {28'h0, 4'(c)});
         clk_chk(c[1:0] != 2'h3, c[3:2] != 2'h3);
      end
      wr(8'hA4, 32'h0);
      // Setup loads only while the load pin is high
      setup_load_en_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      wr(8'h9C, 32'hFFFF_000B);
      rd_chk("setup", 8'h9C, 32'hFFFF_000A);
      chk("addr type", 32'h1, {30'h0, mem0_addr_type_o});
      chk("prefetch", 32'h1, {31'h0, mem0_prefetch_o});
      wr(8'h98, 32'hABCD_E000);
      rd_chk("base masked", 8'h98, 32'hABCD_F000);
      // Back-to-back window hits
      @(posedge clk_sys_i);
      mem0_hit_i <= 1'b1;
      mem0_addr_i <= 32'h1234_5678;
      @(posedge clk_sys_i);
      mem0_addr_i <= 32'h0000_0FFF;
      @(posedge clk_sys_i);
      mem0_hit_i <= 1'b0;
      chk("xlate valid 1", 32'h1, {31'h0, mem0_xlate_valid_o});
      chk("xlate addr 1", 32'hABCD_5678, mem0_xlate_addr_o);
      @(posedge clk_sys_i);
      chk("xlate valid 2", 32'h1, {31'h0, mem0_xlate_valid_o});
      chk("xlate addr 2", 32'hABCD_0FFF, mem0_xlate_addr_o);
      @(posedge clk_sys_i);
      chk("xlate idle", 32'h0, {31'h0, mem0_xlate_valid_o});
      // Zero written to the enable bit
      wr(8'h9C, 32'h7FFF_000A);
      rd_chk("probe base", 8'h98, 32'hFFFF_F000);
      rd_chk("probe setup", 8'h9C, 32'hFFFF_000A);
      setup_load_en_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      wr(8'h9C, 32'h8000_0000);
      rd_chk("setup locked", 8'h9C, 32'hFFFF_000A);
      // Reset in mid-run
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd_chk("base after reset", 8'h98, 32'h0000_0000);
      rd_chk("setup after reset", 8'h9C, 32'hFFFF_F000);
      rd_chk("slot after reset", 8'hA0, 32'h0000_B004);
      clk_chk(1'b1, 1'b1);
      finish_test();
   end
endmodule
